// ==== src/iam_ctrl.v ====
`default_nettype none
`include "iam_consts.vh"
module iam_ctrl (
    input  wire        clk,              // System clock, 25 MHz
    input  wire        rst,              // Synchronous reset, high
    input  wire        standby,          // Hardware standby, high
    input  wire        nonmask_request,  // Nonmaskable request level
    input  wire [5:0]  pin_request_lines,// Pin request levels
    input  wire [5:0]  pin_enable,       // Pin request enables
    input  wire [25:0] mod_request,      // On-chip module requests
    input  wire [25:0] mod_enable,       // On-chip module enables
    input  wire [25:0] mod_to_engine,    // Module routed to transfer
    input  wire [7:0]  level_bank_a,     // Level bits, bank a
    input  wire [7:0]  level_bank_b,     // Level bits, bank b
    input  wire        mode_select_flag, // Mask mode
    input  wire        global_mask_flag, // Condition code mask
    input  wire        secondary_mask_flag, // Condition code 2nd mask
    input  wire [2:0]  mem_config,       // Memory bus configuration
    input  wire [3:0]  ext_wait,         // Wait states per ext access
    input  wire        insn_end,         // Current instruction ends
    input  wire [23:0] resume_pc,        // Address to resume at
    input  wire [31:0] vector_data,      // Routine address fetched
    output reg         busy_q,           // Exception entry running
    output reg         stack_push_q,     // Pulse: push PC and code
    output reg  [23:0] stack_pc_q,       // Stacked program counter
    output reg         set_global_q,     // Pulse: set global mask
    output reg         set_secondary_q,  // Pulse: set second mask
    output reg         vec_fetch_q,      // Pulse: read vector
    output reg  [15:0] vec_addr_q,       // Vector address
    output reg         jump_q,           // Pulse: start routine
    output reg  [23:0] jump_addr_q,      // Routine start address
    output reg  [7:0]  accepted_vec_q    // Vector number accepted
);
    // States
    localparam S_IDLE = 3'h0;
    localparam S_DEC  = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_INT1 = 3'h3;
    localparam S_STK  = 3'h4;
    localparam S_VEC  = 3'h5;
    localparam S_PRE  = 3'h6;
    localparam S_INT2 = 3'h7;

    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg [4:0]  cnt_q;
    reg [4:0]  cnt_d;
    reg        nmi_sel_q;
    reg [4:0]  slot_q;
    wire [31:0] req;
    wire [31:0] lvl;
    wire [31:0] allow;
    reg [3:0]  acc;
    reg [4:0]  acc_len;
    wire       found;
    wire [4:0] pick;
    wire       nmi_live;
    wire       go_nmi;
    wire       go_mask;

    // Slot map: 0..5 pins, 6.. modules; all but pins 0 and 1 share a bank level bit
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : slot
            if (g < `IAM_NPIN) begin : pin
                // Pins 2 and 3 share a level bit, as do 4 and 5
                assign req[g] = pin_request_lines[g]
                              & pin_enable[g];
                assign lvl[g] =
                    level_bank_a[(g < 2) ? 7 - g : 6 - g / 2];
            end else if (g < `IAM_NPIN + `IAM_NMOD) begin : mdl
                // Four vector numbers per level bit (two on bank b bit 5), bank a first
                assign req[g] = mod_request[g-6] & mod_enable[g-6]
                              & ~mod_to_engine[g-6];
                if (g < 22) begin : in_a
                    assign lvl[g] =
                        level_bank_a[3 - (g - 6) / 4];
                end else begin : in_b
                    assign lvl[g] =
                        level_bank_b[7 - (g - 22) / 4];
                end
            end else begin : spare
                assign req[g] = 1'b0;
                assign lvl[g] = 1'b0;
            end
            // Mask gate per mode
            assign allow[g] = mode_select_flag
                ? ~global_mask_flag
                : ~global_mask_flag
                  | (lvl[g] & ~secondary_mask_flag);
        end
    endgenerate

    iam_arbiter u_arb (
        .req   (req),
        .lvl   (lvl),
        .allow (allow),
        .found (found),
        .pick  (pick)
    );

    // Nonmaskable wins over all, blocked only by reset, standby or an entry already running
    assign nmi_live = nonmask_request & ~standby;
    assign go_nmi   = nmi_live;
    assign go_mask  = found & ~standby;

    // Access step length: base by configuration plus waits off chip
    always @* begin
        case (mem_config)
            `IAM_MEM_B8_S2:  acc = `IAM_ACC_B8_S2;
            `IAM_MEM_B8_S3:  acc = `IAM_ACC_B8_S3;
            `IAM_MEM_B16_S2: acc = `IAM_ACC_B16_S2;
            `IAM_MEM_B16_S3: acc = `IAM_ACC_B16_S3;
            default:         acc = `IAM_ACC_ONCHIP;
        endcase
        if (mem_config == `IAM_MEM_ONCHIP)
            acc_len = {1'b0, acc};
        else
            acc_len = {1'b0, acc} + {1'b0, ext_wait};
    end

    // Sequencer next state
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q - 5'h01;
        case (state_q)
            S_IDLE: begin
                cnt_d = 5'h00;
                // Rechecked every cycle, so held requests retry
                if (go_nmi || go_mask) begin
                    state_d = S_DEC;
                    if (go_nmi || pick < `IAM_NPIN)
                        cnt_d = {1'b0, `IAM_DEC_EXT} - 5'h01;
                    else
                        cnt_d = {1'b0, `IAM_DEC_INT} - 5'h01;
                end
            end
            S_DEC: if (cnt_q == 5'h00) begin
                state_d = S_WAIT;
            end
            S_WAIT: if (insn_end) begin
                state_d = S_INT1;
                cnt_d = {1'b0, `IAM_INTERNAL} - 5'h03;
            end
            S_INT1: if (cnt_q == 5'h00) begin
                state_d = S_STK;
                cnt_d = acc_len - 5'h01;
            end
            S_STK: if (cnt_q == 5'h00) begin
                state_d = S_VEC;
                cnt_d = acc_len - 5'h01;
            end
            S_VEC: if (cnt_q == 5'h00) begin
                state_d = S_PRE;
                cnt_d = acc_len - 5'h01;
            end
            S_PRE: if (cnt_q == 5'h00) begin
                state_d = S_INT2;
                cnt_d = {1'b0, `IAM_INTERNAL} - 5'h03;
            end
            S_INT2: if (cnt_q == 5'h00) begin
                state_d = S_IDLE;
                cnt_d = 5'h00;
            end
            default: begin
                state_d = S_IDLE;
                cnt_d = 5'h00;
            end
        endcase
    end

    // Sequencer registers and CPU strobes
    always @(posedge clk) begin
        if (rst) begin
            state_q         <= S_IDLE;
            cnt_q           <= 5'h00;
            nmi_sel_q       <= 1'b0;
            slot_q          <= 5'h00;
            busy_q          <= 1'b0;
            stack_push_q    <= 1'b0;
            stack_pc_q      <= 24'h000000;
            set_global_q    <= 1'b0;
            set_secondary_q <= 1'b0;
            vec_fetch_q     <= 1'b0;
            vec_addr_q      <= 16'h0000;
            jump_q          <= 1'b0;
            jump_addr_q     <= 24'h000000;
            accepted_vec_q  <= 8'h00;
        end else begin
            state_q         <= state_d;
            cnt_q           <= cnt_d;
            stack_push_q    <= 1'b0;
            set_global_q    <= 1'b0;
            set_secondary_q <= 1'b0;
            vec_fetch_q     <= 1'b0;
            jump_q          <= 1'b0;
            busy_q          <= (state_d != S_IDLE);
            // Choice latched at acceptance; losers stay pending at source
            if (state_q == S_IDLE && (go_nmi || go_mask)) begin
                nmi_sel_q <= go_nmi;
                slot_q    <= pick;
                if (go_nmi)
                    accepted_vec_q <= `IAM_VEC_NONMASK;
                else if (pick < `IAM_NPIN)
                    accepted_vec_q <= `IAM_VEC_PIN0 + {3'h0, pick};
                else
                    accepted_vec_q <= `IAM_VEC_MOD0
                                    + {3'h0, pick} - 8'h06;
            end
            // Resume address taken when the instruction ends
            if (state_q == S_WAIT && insn_end)
                stack_pc_q <= resume_pc;
            if (state_q == S_INT1 && cnt_q == 5'h00)
                stack_push_q <= 1'b1;
            // Masks raised once stacking is done
            if (state_q == S_STK && cnt_q == 5'h00) begin
                set_global_q    <= 1'b1;
                set_secondary_q <= ~mode_select_flag;
                vec_fetch_q     <= 1'b1;
                vec_addr_q      <= {6'h00, accepted_vec_q, 2'b00};
            end
            if (state_q == S_VEC && cnt_q == 5'h00)
                jump_addr_q <= vector_data[23:0];
            if (state_q == S_INT2 && cnt_q == 5'h00)
                jump_q <= 1'b1;
        end
    end
endmodule // iam_ctrl
`default_nettype wire

// ==== src/iam_consts.vh ====
`ifndef IAM_CONSTS_VH
`define IAM_CONSTS_VH
// Source counts
`define IAM_NSRC            6'd32
`define IAM_NPIN            6
`define IAM_NMOD            26
`define IAM_NGRP            16
// Vector numbers
`define IAM_VEC_NONMASK     8'h07
`define IAM_VEC_PIN0        8'h0c
`define IAM_VEC_MOD0        8'h14
// Priority decision states
`define IAM_DEC_EXT         4'h2
`define IAM_DEC_INT         4'h1
// Access step states per memory configuration
`define IAM_ACC_ONCHIP      4'h4
`define IAM_ACC_B8_S2       4'h8
`define IAM_ACC_B8_S3       4'hc
`define IAM_ACC_B16_S2      4'h4
`define IAM_ACC_B16_S3      4'h6
`define IAM_INTERNAL        4'h4
// Memory configuration codes
`define IAM_MEM_ONCHIP      3'h0
`define IAM_MEM_B8_S2       3'h1
`define IAM_MEM_B8_S3       3'h2
`define IAM_MEM_B16_S2      3'h3
`define IAM_MEM_B16_S3      3'h4
`endif

// ==== src/iam_arbiter.v ====
`default_nettype none
`include "iam_consts.vh"
// Picks the winner among 32 request slots: level first, then slot order.
// Slot 0 has the smallest vector number and wins ties.
module iam_arbiter (
    input  wire [31:0] req,        // Requests, unmasked
    input  wire [31:0] lvl,        // Priority level per slot
    input  wire [31:0] allow,      // Mask gate per slot
    output reg         found,      // Some request passes the gate
    output reg  [4:0]  pick        // Winning slot index
);
    integer i;
    reg [31:0] ok;

    // Highest slot scanned first so the lowest wins ties
    always @* begin
        ok = req & allow;
        found = 1'b0;
        pick = 5'h00;
        for (i = 31; i >= 0; i = i - 1) begin
            if (ok[i] && lvl[i] == 1'b0) begin
                found = 1'b1;
                pick = i[4:0];
            end
        end
        for (i = 31; i >= 0; i = i - 1) begin
            if (ok[i] && lvl[i]) begin
                found = 1'b1;
                pick = i[4:0];
            end
        end
    end
endmodule // iam_arbiter
`default_nettype wire

// ==== testbench/iam_ctrl_assertions.sv ====
`default_nettype none
module iam_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        standby,
    input wire logic        nonmask_request,
    input wire logic [5:0]  pin_request_lines,
    input wire logic [5:0]  pin_enable,
    input wire logic [25:0] mod_request,
    input wire logic [25:0] mod_enable,
    input wire logic [25:0] mod_to_engine,
    input wire logic        mode_select_flag,
    input wire logic        global_mask_flag,
    input wire logic        secondary_mask_flag,
    input wire logic [2:0]  mem_config,
    input wire logic        busy_q,
    input wire logic        stack_push_q,
    input wire logic        set_global_q,
    input wire logic        set_secondary_q,
    input wire logic        vec_fetch_q,
    input wire logic [15:0] vec_addr_q,
    input wire logic [7:0]  accepted_vec_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Idle with no nonmaskable request
    wire logic quiet = !busy_q && !nonmask_request;
    AST_STBY: assert property (!busy_q && standby |=> !busy_q)
        else $error("entry started in standby");
    AST_NMI: assert property (!busy_q && nonmask_request
        && !standby |=> busy_q && accepted_vec_q == 8'h07)
        else $error("nmi not taken");
    AST_M1: assert property (quiet && mode_select_flag
        && global_mask_flag |=> !busy_q)
        else $error("masked entry in mode 1");
    AST_M0: assert property (quiet && !mode_select_flag
        && global_mask_flag && secondary_mask_flag |=> !busy_q)
        else $error("masked entry in mode 0");
    AST_OFF: assert property (quiet
        && !(|(pin_request_lines & pin_enable))
        && !(|(mod_request & mod_enable & ~mod_to_engine)) |=> !busy_q)
        else $error("entry without enabled source");
    AST_MSK: assert property (vec_fetch_q
        |-> set_global_q && set_secondary_q == !mode_select_flag)
        else $error("mask set wrong");
    AST_VEC: assert property (vec_fetch_q
        |-> vec_addr_q == {6'h00, accepted_vec_q, 2'h0})
        else $error("bad vector");
    AST_ACC: assert property (stack_push_q && mem_config == 3'h0
        |-> ##4 vec_fetch_q) else $error("stack step length wrong");
    // Main scenarios
    cover property (vec_fetch_q && !mode_select_flag);
    cover property (vec_fetch_q && accepted_vec_q == 8'h07);
    cover property (stack_push_q && mem_config == 3'h1);
endmodule // iam_checker
bind iam_ctrl iam_checker i_iam_checker (.clk(clk), .rst(rst),
    .standby(standby), .nonmask_request(nonmask_request),
    .pin_request_lines(pin_request_lines), .pin_enable(pin_enable),
    .mod_request(mod_request), .mod_enable(mod_enable),
    .mod_to_engine(mod_to_engine), .mode_select_flag(mode_select_flag),
    .global_mask_flag(global_mask_flag),
    .secondary_mask_flag(secondary_mask_flag), .mem_config(mem_config),
    .busy_q(busy_q), .stack_push_q(stack_push_q),
    .set_global_q(set_global_q), .set_secondary_q(set_secondary_q),
    .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q),
    .accepted_vec_q(accepted_vec_q));
`default_nettype wire

// ==== testbench/iam_cpu_model.sv ====
`default_nettype none
module iam_cpu_model #(
    parameter int DLY = 3                  // Cycles left of instruction
) (
    input  wire logic        clk,          // System clock
    input  wire logic        rst,          // Reset, high
    input  wire logic        busy_q,       // Entry running
    input  wire logic        jump_q,       // Routine start
    input  wire logic [15:0] vec_addr_q,   // Vector address
    output logic             insn_end,     // Instruction done
    output logic [23:0]      resume_pc,    // Next instruction
    output logic [31:0]      vector_data   // Routine address read
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic       seen_q;
    // Instruction ends once, some cycles into the entry
    always @(posedge clk) begin
        if (rst || !busy_q) begin
            cnt_q  <= 4'h0;
            seen_q <= 1'b0;
        end else if (!seen_q) begin
            cnt_q  <= cnt_q + 4'h1;
            seen_q <= (cnt_q == DLY);
        end
    end
    assign insn_end = busy_q && !seen_q && (cnt_q == DLY);
    // Program runs on while idle, frozen during entry
    always @(posedge clk) begin
        if (rst) resume_pc <= 24'h000100;
        else if (!busy_q) resume_pc <= resume_pc + 24'h2;
    end
    // Bus floats to the inverse outside the entry
    assign vector_data = (busy_q || jump_q) ? {16'h00a5, vec_addr_q}
        : ~{16'h00a5, vec_addr_q};
endmodule // iam_cpu_model
`default_nettype wire

// ==== testbench/tb_iam_ctrl.sv ====
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %0h got %0h", nm, e, g); failures++; end end
`define WAIT(s, lim) begin n = 0; while ((s) !== 1'b1 && n < lim) begin \
    @(negedge clk); n++; end end
module tb_iam_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic m, g, s, nmi;
        logic [5:0] pin, pen;
        logic [25:0] mr, me, eng;
        logic [7:0] la;
        logic [2:0] mem;
        logic [3:0] wt;
        logic [7:0] vec;
        int len;
    } iam_row_t;
    logic clk = 1'b0, rst = 1'b1, standby = 1'b0;
    logic [7:0] lb = 8'h00;
    iam_row_t cur = '{default: '0};
    logic busy_q, stack_push_q, set_global_q, set_secondary_q;
    logic vec_fetch_q, jump_q, insn_end;
    logic [23:0] stack_pc_q, jump_addr_q, resume_pc;
    logic [15:0] vec_addr_q;
    logic [7:0]  accepted_vec_q;
    logic [31:0] vector_data;
    int failures = 0, check_count = 0, n;
    // Mask mode, masks, requests, levels, bus setup, expected vector, steps
    iam_row_t rows [10] = '{
        '{1,0,1,0,6'h5,6'h3f,26'h0,26'h0,26'h0,8'h0,3'h0,4'h3,8'hc,14},
        '{1,1,0,0,6'h1,6'h3f,26'h0,26'h0,26'h0,8'h80,3'h0,4'h0,8'h0,0},
        '{1,1,0,1,6'h1,6'h3f,26'h0,26'h0,26'h0,8'h80,3'h1,4'h2,8'h7,32},
        '{0,0,1,0,6'h3,6'h3f,26'h0,26'h0,26'h0,8'h40,3'h2,4'h0,8'hd,38},
        '{0,1,0,0,6'h3,6'h3f,26'h0,26'h0,26'h0,8'h40,3'h3,4'h1,8'hd,17},
        '{0,1,0,0,6'h1,6'h3f,26'h0,26'h0,26'h0,8'h40,3'h0,4'h0,8'h0,0},
        '{0,1,1,0,6'h2,6'h3f,26'h0,26'h0,26'h0,8'h40,3'h0,4'h0,8'h0,0},
        '{1,0,0,0,6'h1,6'h00,26'h0,26'h0,26'h0,8'h0,3'h0,4'h0,8'h0,0},
        '{1,0,0,0,6'h0,6'h3f,26'h1,26'h1,26'h1,8'h0,3'h0,4'h0,8'h0,0},
        '{1,0,0,0,6'h0,6'h3f,26'h3,26'h2,26'h0,8'h0,3'h4,4'h0,8'h15,20}};
    iam_ctrl i_iam_ctrl (.clk(clk), .rst(rst), .standby(standby),
        .nonmask_request(cur.nmi), .pin_request_lines(cur.pin),
        .pin_enable(cur.pen), .mod_request(cur.mr), .mod_enable(cur.me),
        .mod_to_engine(cur.eng), .level_bank_a(cur.la),
        .level_bank_b(lb), .mode_select_flag(cur.m),
        .global_mask_flag(cur.g), .secondary_mask_flag(cur.s),
        .mem_config(cur.mem), .ext_wait(cur.wt), .insn_end(insn_end),
        .resume_pc(resume_pc), .vector_data(vector_data), .busy_q(busy_q),
        .stack_push_q(stack_push_q), .stack_pc_q(stack_pc_q),
        .set_global_q(set_global_q), .set_secondary_q(set_secondary_q),
        .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q),
        .jump_q(jump_q), .jump_addr_q(jump_addr_q),
        .accepted_vec_q(accepted_vec_q));
    iam_cpu_model #(.DLY(3)) i_iam_cpu_model (.clk(clk), .rst(rst),
        .busy_q(busy_q), .jump_q(jump_q), .vec_addr_q(vec_addr_q),
        .insn_end(insn_end), .resume_pc(resume_pc),
        .vector_data(vector_data));
    always #20 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One entry, or none when vec is zero; requests dropped after the jump
    task automatic entry(input logic [7:0] vec, input int len);
        `WAIT(busy_q, 8)
        `CHK("busy", vec != 8'h00, busy_q)
        if (busy_q === 1'b1) begin
            `CHK("vector", vec, accepted_vec_q)
            `WAIT(stack_push_q, 60)
            `WAIT(jump_q, 99)
            if (jump_q !== 1'b1) begin
                failures++;
                finish_test();
            end
            `CHK("steps", len, n)
            `CHK("routine", {8'ha5, 6'h0, vec, 2'h0}, jump_addr_q)
            `CHK("stacked pc", resume_pc, stack_pc_q)
        end
        cur = '{default: '0};
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            cur = rows[i];
            entry(rows[i].vec, rows[i].len);
        end
        // Held request is taken once its mask clears
        cur = rows[1];
        repeat (6) @(negedge clk);
        `CHK("held", 1'b0, busy_q)
        cur.g = 1'b0;
        entry(8'hc, 14);
        // Standby blocks even the nonmaskable request
        standby = 1'b1;
        cur.nmi = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("standby", 1'b0, busy_q)
        standby = 1'b0;
        entry(8'h7, 14);
        // Pin 3 shares its level bit with pin 2; pin 0 stays masked
        cur.pin = 6'h09;
        cur.pen = 6'h3f;
        cur.la = 8'h20;
        cur.g = 1'b1;
        entry(8'h0f, 14);
        // Bank b top bit lets vector 36 through while vector 24 stays masked
        lb = 8'h80;
        cur.mr = 26'h0010010;
        cur.me = 26'h0010010;
        cur.g = 1'b1;
        entry(8'h24, 14);
        lb = 8'h00;
        // Reset in mid-entry clears everything
        cur.nmi = 1'b1;
        `WAIT(busy_q, 8)
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        cur = '{default: '0};
        `CHK("reset busy", 1'b0, busy_q)
        `CHK("reset vector", 8'h00, accepted_vec_q)
        finish_test();
    end
endmodule // tb_iam_ctrl
`default_nettype wire
